// [ueba_top.sv]
// Endpoint buffer address generation, suspend detection and clock gating with an APB slave.
// How it works
// - Each endpoint length selects 8, 16, 32 or 64 bytes.
// - Setup packets always go to buffer address zero.
// - An unused endpoint has length zero and uses no buffer memory.
// - The endpoint index picks that endpoint's own base pointer.
// - Buffer address is base pointer plus byte offset.
// - No start of frame for over 3 ms raises the suspend begin request.
// - Entering suspend sets the suspend flag in the control register.
// - A valid bus level during suspend raises the suspend end request.
// - Memory management runs at the CPU clock rate.
// - Writing one to the clock off bit stops the memory clock.
// - The 48 MHz core clock is gated by the core clock gate bit.
// - Suspend end is detected even with the core clock gated.
// - With auto increment set, each CPU buffer access bumps the offset.
`include "ueba_consts.svh"
`default_nettype none
module ueba_top
  import ueba_pkg::*;
#(
  parameter int unsigned SUSPEND_FLAG_CYCLES = `UEBA_SUSPEND_FLAG_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sof_seen,
  input  wire logic        bus_resume,
  input  wire logic        usb_access,
  input  wire logic        usb_setup,
  input  wire logic [3:0]  endpoint_index,
  input  wire logic [7:0]  usb_byte_offset,
  output logic      [7:0]  buf_addr,
  output logic             buf_addr_valid,
  output logic             mem_clk_en,
  output logic             core_clk_en,
  output logic             suspend_begin_irq,
  output logic             suspend_end_irq
);

  typedef struct packed
  {
    logic [`UEBA_NUM_EP-1:0][7:0] base;
    ueba_len_t [`UEBA_NUM_EP-1:0] len;
    logic [`UEBA_NUM_EP-1:0][7:0] offset;
    logic [3:0]  cpu_ep;
    logic        core_clock_gate;
    logic        buffer_clock_off;
    logic        auto_increment_select;
    ueba_state_t state;
    logic [31:0] idle_cnt;
    logic        begin_irq;
    logic        end_irq;
    logic [7:0]  addr;
    logic        addr_valid;
    logic [31:0] rdata;
    logic [1:0]  sof_sync;
    logic [1:0]  res_sync;
    logic [1:0]  acc_sync;
    logic        acc_prev;
    logic [1:0]  stp_sync;
    logic [1:0][3:0] idx_sync;
    logic [1:0][7:0] boff_sync;
  } ueba_regs_t;

  ueba_regs_t r_q;
  ueba_regs_t r_d;

  function automatic logic [7:0] ueba_len_bytes(input ueba_len_t l);
    case (l)
      UEBA_LEN_8:  ueba_len_bytes = 8'h08;
      UEBA_LEN_16: ueba_len_bytes = 8'h10;
      UEBA_LEN_32: ueba_len_bytes = 8'h20;
      UEBA_LEN_64: ueba_len_bytes = 8'h40;
      default:     ueba_len_bytes = 8'h00;
    endcase
  endfunction

  function automatic ueba_len_t ueba_len_code(input logic [7:0] n);
    case (n)
      8'h08:   ueba_len_code = UEBA_LEN_8;
      8'h10:   ueba_len_code = UEBA_LEN_16;
      8'h20:   ueba_len_code = UEBA_LEN_32;
      8'h40:   ueba_len_code = UEBA_LEN_64;
      default: ueba_len_code = UEBA_LEN_NONE;
    endcase
  endfunction

  function automatic logic [7:0] ueba_address(input logic [7:0] b, input logic [7:0] o);
    ueba_address = 8'(b + o);
  endfunction

  function automatic logic ueba_mapped(input logic [11:0] a);
    ueba_mapped = (a[11:6] == 6'h00) && (a[1:0] == 2'b00) && (a[5:2] <= 4'h8);
  endfunction

  logic wr_en;
  logic rd_en;
  logic acc_rise;
  logic [11:0] off;
  // Event flags let a new interrupt event win over a clear in the same cycle.
  logic        begin_evt;
  logic        end_evt;

  always_comb
  begin
    r_d      = r_q;
    off      = paddr;
    wr_en    = psel && penable && pwrite;
    rd_en    = psel && penable && !pwrite;
    acc_rise = r_q.acc_sync[1] && !r_q.acc_prev;
    begin_evt = 1'b0;
    end_evt   = 1'b0;
    r_d.sof_sync = {r_q.sof_sync[0], sof_seen};
    r_d.res_sync = {r_q.res_sync[0], bus_resume};
    r_d.acc_sync = {r_q.acc_sync[0], usb_access};
    r_d.acc_prev = r_q.acc_sync[1];
    // Qualifiers pass the same two flip-flops as the access strobe.
    r_d.stp_sync  = {r_q.stp_sync[0], usb_setup};
    r_d.idx_sync  = {r_q.idx_sync[0], endpoint_index};
    r_d.boff_sync = {r_q.boff_sync[0], usb_byte_offset};
    // Address of the current USB byte.
    r_d.addr_valid = acc_rise;
    if (acc_rise)
    begin
      if (r_q.stp_sync[1])
      begin
        r_d.addr = 8'(`UEBA_SETUP_BASE + r_q.boff_sync[1]);
      end
      else if (r_q.len[r_q.idx_sync[1]] == UEBA_LEN_NONE)
      begin
        r_d.addr_valid = 1'b0;
      end
      else
      begin
        r_d.addr = ueba_address(r_q.base[r_q.idx_sync[1]], r_q.boff_sync[1]);
      end
    end
    // Suspend detection.
    case (r_q.state)
      UEBA_ST_ACTIVE:
      begin
        if (r_q.sof_sync[1])
        begin
          r_d.idle_cnt = 32'h0000_0000;
        end
        else if (r_q.idle_cnt >= 32'(SUSPEND_FLAG_CYCLES))
        begin
          r_d.state     = UEBA_ST_SUSPEND;
          r_d.begin_irq = 1'b1;
          begin_evt     = 1'b1;
          r_d.idle_cnt  = 32'h0000_0000;
        end
        else
        begin
          r_d.idle_cnt = r_q.idle_cnt + 32'h0000_0001;
        end
      end
      UEBA_ST_SUSPEND:
      begin
        if (r_q.res_sync[1] || r_q.sof_sync[1])
        begin
          r_d.state   = UEBA_ST_ACTIVE;
          r_d.end_irq = 1'b1;
          end_evt     = 1'b1;
        end
      end
      default:
      begin
        r_d.state = UEBA_ST_ACTIVE;
      end
    endcase
    // Register reads.
    r_d.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `UEBA_OFF_CTRL:   r_d.rdata = 32'({r_q.auto_increment_select,
                                          r_q.state == UEBA_ST_SUSPEND, r_q.core_clock_gate});
        `UEBA_OFF_CLKCFG: r_d.rdata = 32'(r_q.buffer_clock_off);
        `UEBA_OFF_IRQ:    r_d.rdata = 32'({r_q.end_irq, r_q.begin_irq});
        `UEBA_OFF_EPSEL:  r_d.rdata = 32'(r_q.cpu_ep);
        `UEBA_OFF_EPBASE: r_d.rdata = 32'(r_q.base[r_q.cpu_ep]);
        `UEBA_OFF_ENDPOINT_BLOCK_LENGTH:  r_d.rdata = 32'(ueba_len_bytes(r_q.len[r_q.cpu_ep]));
        `UEBA_OFF_OFFSET: r_d.rdata = 32'(r_q.offset[r_q.cpu_ep]);
        `UEBA_OFF_ADDR:   r_d.rdata = 32'(ueba_address(r_q.base[r_q.cpu_ep],
                                                       r_q.offset[r_q.cpu_ep]));
        default:          r_d.rdata = 32'h0000_0000;
      endcase
    end
    // CPU buffer access bumps the offset when sequential mode is on.
    if (psel && penable && paddr == `UEBA_OFF_ACCESS && r_q.auto_increment_select)
    begin
      r_d.offset[r_q.cpu_ep] = r_q.offset[r_q.cpu_ep] + 8'h01;
    end
    // Register writes; a write of one clears an interrupt bit, but a new event wins.
    if (wr_en)
    begin
      case (off)
        `UEBA_OFF_CTRL:
        begin
          r_d.core_clock_gate       = pwdata[`UEBA_CTRL_GATE_BIT];
          r_d.auto_increment_select = pwdata[`UEBA_CTRL_INCR_BIT];
        end
        `UEBA_OFF_CLKCFG: r_d.buffer_clock_off = pwdata[`UEBA_CLK_OFF_BIT];
        `UEBA_OFF_IRQ:
        begin
          if (pwdata[`UEBA_IRQ_BEGIN_BIT] && !begin_evt)
          begin
            r_d.begin_irq = 1'b0;
          end
          if (pwdata[`UEBA_IRQ_END_BIT] && !end_evt)
          begin
            r_d.end_irq = 1'b0;
          end
        end
        `UEBA_OFF_EPSEL:  r_d.cpu_ep = pwdata[3:0];
        `UEBA_OFF_EPBASE: r_d.base[r_q.cpu_ep] = pwdata[7:0];
        `UEBA_OFF_ENDPOINT_BLOCK_LENGTH:  r_d.len[r_q.cpu_ep] = ueba_len_code(pwdata[7:0]);
        `UEBA_OFF_OFFSET: r_d.offset[r_q.cpu_ep] = pwdata[7:0];
        default:          r_d.cpu_ep = r_q.cpu_ep;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  logic mapped;
  assign mapped = ueba_mapped(paddr);

  // Outputs other than pready and pslverr come straight from the registered state.
  assign pready            = 1'b1;
  assign pslverr           = psel && penable && !mapped;
  assign prdata            = r_q.rdata;
  assign buf_addr          = r_q.addr;
  assign buf_addr_valid    = r_q.addr_valid;
  assign mem_clk_en        = !r_q.buffer_clock_off;
  assign core_clk_en       = r_q.core_clock_gate;
  assign suspend_begin_irq = r_q.begin_irq;
  assign suspend_end_irq   = r_q.end_irq;

  a_suspend_begin: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r_q.state == UEBA_ST_SUSPEND) |-> suspend_begin_irq)
    else $error("Suspend entered without begin request.");
  a_suspend_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(suspend_begin_irq) |-> r_q.state == UEBA_ST_SUSPEND)
    else $error("Begin request without suspend flag.");
  a_suspend_end: assert property (@(posedge pclk) disable iff (!presetn)
    (r_q.state == UEBA_ST_SUSPEND && r_q.res_sync[1]) |=> suspend_end_irq)
    else $error("Resume did not raise end request.");
  a_end_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (!core_clk_en && r_q.state == UEBA_ST_SUSPEND && r_q.res_sync[1]) |=> suspend_end_irq)
    else $error("End request lost with core clock gated.");
  a_addr_sum: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_rise && !r_q.stp_sync[1] && r_q.len[r_q.idx_sync[1]] != UEBA_LEN_NONE)
      |=> buf_addr == 8'($past(r_q.base[r_q.idx_sync[1]]) + $past(r_q.boff_sync[1])))
    else $error("Buffer address is not base plus offset.");
  a_setup_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_rise && r_q.stp_sync[1]) |=> buf_addr == $past(r_q.boff_sync[1]))
    else $error("Setup packet not at address zero.");
  a_unused_ep: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_rise && !r_q.stp_sync[1] && r_q.len[r_q.idx_sync[1]] == UEBA_LEN_NONE)
      |=> !buf_addr_valid)
    else $error("Unused endpoint produced an address.");
  a_offset_incr: assert property (@(posedge pclk) disable iff (!presetn)
    ((rd_en || wr_en) && paddr == `UEBA_OFF_ACCESS && r_q.auto_increment_select)
      |=> r_q.offset[$past(r_q.cpu_ep)] == 8'($past(r_q.offset[r_q.cpu_ep]) + 8'h01))
    else $error("Offset did not advance after access.");
  a_clk_off: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `UEBA_OFF_CLKCFG && pwdata[0]) |=> !mem_clk_en)
    else $error("Memory clock not stopped.");
  a_clk_on: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `UEBA_OFF_CLKCFG && !pwdata[`UEBA_CLK_OFF_BIT]) |=> mem_clk_en)
    else $error("Memory clock not restarted.");
  a_core_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `UEBA_OFF_CTRL) |=> core_clk_en == $past(pwdata[`UEBA_CTRL_GATE_BIT]))
    else $error("Core clock gate does not follow the control write.");

  // Named steps of the address strobe and of the suspend handshake.
  sequence s_usb_take;
    acc_rise && (r_q.stp_sync[1] || r_q.len[r_q.idx_sync[1]] != UEBA_LEN_NONE);
  endsequence
  sequence s_one_pulse;
    buf_addr_valid ##1 !buf_addr_valid;
  endsequence
  sequence s_quiet_full;
    r_q.state == UEBA_ST_ACTIVE && !r_q.sof_sync[1] && r_q.idle_cnt >= 32'(SUSPEND_FLAG_CYCLES);
  endsequence
  sequence s_resume_seen;
    r_q.state == UEBA_ST_SUSPEND && (r_q.res_sync[1] || r_q.sof_sync[1]);
  endsequence

  a_addr_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_usb_take |=> s_one_pulse)
    else $error("Address strobe is not a single pulse.");
  a_suspend_flag_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_quiet_full |=> suspend_begin_irq && r_q.state == UEBA_ST_SUSPEND)
    else $error("Quiet bus did not enter suspend.");
  a_suspend_flag_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r_q.state == UEBA_ST_SUSPEND) |-> $past(r_q.idle_cnt) >= 32'(SUSPEND_FLAG_CYCLES))
    else $error("Suspend entered before the quiet time ran out.");
  a_suspend_flag_exit: assert property (@(posedge pclk) disable iff (!presetn)
    s_resume_seen |=> suspend_end_irq && r_q.state == UEBA_ST_ACTIVE)
    else $error("Bus activity did not end suspend.");
  a_len_unused: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `UEBA_OFF_ENDPOINT_BLOCK_LENGTH
      && !(pwdata[7:0] inside {8'h08, 8'h10, 8'h20, 8'h40}))
      |=> r_q.len[$past(r_q.cpu_ep)] == UEBA_LEN_NONE)
    else $error("Unsupported length not stored as zero.");
  a_len_code: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `UEBA_OFF_ENDPOINT_BLOCK_LENGTH && pwdata[7:0] inside {8'h08, 8'h10, 8'h20, 8'h40})
      |=> ueba_len_bytes(r_q.len[$past(r_q.cpu_ep)]) == $past(pwdata[7:0]))
    else $error("Supported length not stored.");
  a_addr_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == `UEBA_OFF_ADDR)
      |=> prdata[7:0] == 8'($past(r_q.base[r_q.cpu_ep]) + $past(r_q.offset[r_q.cpu_ep])))
    else $error("Address register is not base plus offset.");
  a_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == `UEBA_OFF_CTRL)
      |=> prdata[`UEBA_CTRL_SUSPEND_FLAG_BIT] == $past(r_q.state == UEBA_ST_SUSPEND))
    else $error("Control read does not show the suspend flag.");

endmodule
`default_nettype wire

// [ueba_consts.svh]
// Offsets, field positions, reset values and timing counts of the endpoint buffer addressing block.
`ifndef UEBA_CONSTS_SVH
`define UEBA_CONSTS_SVH
`define UEBA_OFF_CTRL        12'h000
`define UEBA_OFF_CLKCFG      12'h004
`define UEBA_OFF_IRQ         12'h008
`define UEBA_OFF_EPSEL       12'h00C
`define UEBA_OFF_EPBASE      12'h010
`define UEBA_OFF_ENDPOINT_BLOCK_LENGTH       12'h014
`define UEBA_OFF_OFFSET      12'h018
`define UEBA_OFF_ACCESS      12'h01C
`define UEBA_OFF_ADDR        12'h020
`define UEBA_CTRL_GATE_BIT   0
`define UEBA_CTRL_SUSPEND_FLAG_BIT   1
`define UEBA_CTRL_INCR_BIT   2
`define UEBA_CLK_OFF_BIT     0
`define UEBA_IRQ_BEGIN_BIT   0
`define UEBA_IRQ_END_BIT     1
`define UEBA_NUM_EP          16
`define UEBA_SUSPEND_FLAG_TIME_NS    3000000
`define UEBA_CLK_PERIOD_NS   40
`define UEBA_SUSPEND_FLAG_CYCLES     ((`UEBA_SUSPEND_FLAG_TIME_NS + `UEBA_CLK_PERIOD_NS - 1) / `UEBA_CLK_PERIOD_NS)
`define UEBA_SETUP_BASE      8'h00
`define UEBA_RESET_BASE      8'h00
`endif

// [ueba_pkg.sv]
// Types shared by the endpoint buffer addressing block.
`default_nettype none
package ueba_pkg;
  typedef enum logic [2:0]
  {
    UEBA_LEN_NONE = 3'b000,
    UEBA_LEN_8    = 3'b001,
    UEBA_LEN_16   = 3'b011,
    UEBA_LEN_32   = 3'b010,
    UEBA_LEN_64   = 3'b110
  } ueba_len_t;
  typedef enum logic [1:0]
  {
    UEBA_ST_ACTIVE  = 2'b00,
    UEBA_ST_SUSPEND = 2'b01
  } ueba_state_t;
endpackage
`default_nettype wire

// [ueba_host_model.sv]
// USB-side model that drives frame markers, resume level and buffer byte accesses.
`default_nettype none
module ueba_host_model
(
  input  wire logic       pclk,
  input  wire logic       frames_on,
  output var  logic       sof_seen,
  output var  logic       bus_resume,
  output var  logic       usb_access,
  output var  logic       usb_setup,
  output var  logic [3:0] endpoint_index,
  output var  logic [7:0] usb_byte_offset
);
  timeunit 1ns;
  timeprecision 1ps;
  int tick = 0;
  initial
  begin
    bus_resume = 1'b0;
    usb_access = 1'b0;
    usb_setup = 1'b0;
    endpoint_index = 4'h0;
    usb_byte_offset = 8'h00;
  end
  // Frame markers come every ten cycles while frames run.
  always @(posedge pclk)
  begin
    tick <= (tick == 9) ? 0 : tick + 1;
    sof_seen <= frames_on && (tick == 0);
  end
  // Index, offset and setup stay stable around the access, then change.
  task automatic access(input logic [3:0] ep, input logic [7:0] off, input logic stp);
    @(posedge pclk);
    endpoint_index <= ep;
    usb_byte_offset <= off;
    usb_setup <= stp;
    @(posedge pclk);
    usb_access <= 1'b1;
    repeat (4) @(posedge pclk);
    usb_access <= 1'b0;
    repeat (3) @(posedge pclk);
    endpoint_index <= ~ep;
    usb_byte_offset <= ~off;
    usb_setup <= ~stp;
  endtask
  task automatic resume_mark;
    @(posedge pclk);
    bus_resume <= 1'b1;
    repeat (3) @(posedge pclk);
    bus_resume <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb_usb_endpoint_buffer_addressing.sv]
// Self-checking bench for the endpoint buffer addressing block.
`include "ueba_consts.svh"
`default_nettype none
module tb_usb_endpoint_buffer_addressing;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SC = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, frames_on;
  logic        sof_seen, bus_resume, usb_access, usb_setup, buf_addr_valid;
  logic        mem_clk_en, core_clk_en, suspend_begin_irq, suspend_end_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  endpoint_index;
  logic [7:0]  usb_byte_offset, buf_addr, off;
  int          n_mismatch, total_checks, i, j, cnt, exp_v;
  int          mbase[16], mlen[16], exp_q[$];
  int          bases[5] = '{8'hf8, 8'h10, 8'h20, 8'hc0, 8'h40};
  int          lens[5] = '{8, 16, 32, 64, 24};
  integer      seed = 32'ha748_f97a;
  ueba_top #(.SUSPEND_FLAG_CYCLES(SC)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sof_seen(sof_seen), .bus_resume(bus_resume),
    .usb_access(usb_access), .usb_setup(usb_setup), .endpoint_index(endpoint_index),
    .usb_byte_offset(usb_byte_offset), .buf_addr(buf_addr), .buf_addr_valid(buf_addr_valid),
    .mem_clk_en(mem_clk_en), .core_clk_en(core_clk_en),
    .suspend_begin_irq(suspend_begin_irq), .suspend_end_irq(suspend_end_irq));
  ueba_host_model u_host (.pclk(pclk), .frames_on(frames_on), .sof_seen(sof_seen),
    .bus_resume(bus_resume), .usb_access(usb_access), .usb_setup(usb_setup),
    .endpoint_index(endpoint_index), .usb_byte_offset(usb_byte_offset));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic timed_out(input int n, input int lim);
    if (n >= lim)
    begin
      n_mismatch++;
      $display("wait ran out at %0t", $time);
      tally_and_finish();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 8; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    timed_out(n, 8);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // Every address pulse is compared with the next queued expectation.
  always @(posedge pclk)
  begin
    if (buf_addr_valid === 1'b1)
    begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 256;
      chk(32'(buf_addr), 32'(exp_v));
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, frames_on} = '0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    frames_on <= 1'b1;
    chk(32'({mem_clk_en, core_clk_en, suspend_begin_irq}), 32'h0000_0004);
    rdchk(`UEBA_OFF_CTRL, 32'h0000_0000);
    rdchk(`UEBA_OFF_CLKCFG, 32'h0000_0000);
    rdchk(12'h040, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    $display("reset and unmapped test done");
    for (i = 0; i < 5; i++)
    begin
      mbase[i + 1] = bases[i];
      mlen[i + 1] = (lens[i] inside {8, 16, 32, 64}) ? lens[i] : 0;
      apb(1'b1, `UEBA_OFF_EPSEL, 32'(i + 1));
      apb(1'b1, `UEBA_OFF_EPBASE, 32'(bases[i]));
      apb(1'b1, `UEBA_OFF_ENDPOINT_BLOCK_LENGTH, 32'(lens[i]));
      rdchk(`UEBA_OFF_ENDPOINT_BLOCK_LENGTH, 32'(mlen[i + 1]));
      rdchk(`UEBA_OFF_EPBASE, 32'(mbase[i + 1]));
    end
    for (i = 1; i < 6; i++)
      for (j = 0; j < 2; j++)
      begin
        off = 8'($random(seed)) & 8'((mlen[i] > 0) ? mlen[i] - 1 : 7);
        if (mlen[i] > 0)
          exp_q.push_back((mbase[i] + off) & 255);
        u_host.access(4'(i), off, 1'b0);
      end
    off = 8'($random(seed)) & 8'h07;
    exp_q.push_back(int'(off));
    u_host.access(4'd4, off, 1'b1);
    repeat (3) @(posedge pclk);
    chk(32'(exp_q.size()), 32'h0000_0000);
    $display("usb address test done");
    apb(1'b1, `UEBA_OFF_CTRL, 32'h0000_0004);
    apb(1'b1, `UEBA_OFF_EPSEL, 32'h0000_0003);
    apb(1'b1, `UEBA_OFF_OFFSET, 32'h0000_0000);
    for (i = 0; i < 3; i++)
      apb(i[0], `UEBA_OFF_ACCESS, 32'h0000_005a);
    rdchk(`UEBA_OFF_OFFSET, 32'h0000_0003);
    rdchk(`UEBA_OFF_ADDR, 32'(mbase[3] + 3));
    apb(1'b1, `UEBA_OFF_CTRL, 32'h0000_0000);
    apb(1'b0, `UEBA_OFF_ACCESS, 32'h0000_0000);
    rdchk(`UEBA_OFF_OFFSET, 32'h0000_0003);
    $display("auto increment test done");
    apb(1'b1, `UEBA_OFF_CLKCFG, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(32'(mem_clk_en), 32'h0000_0000);
    apb(1'b1, `UEBA_OFF_CLKCFG, 32'h0000_0000);
    apb(1'b1, `UEBA_OFF_CTRL, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(32'({mem_clk_en, core_clk_en}), 32'h0000_0003);
    rdchk(`UEBA_OFF_IRQ, 32'h0000_0000);
    $display("clock gating test done");
    for (cnt = 0; cnt < 20 && sof_seen !== 1'b1; cnt++)
      @(posedge pclk);
    timed_out(cnt, 20);
    frames_on <= 1'b0;
    for (cnt = 0; cnt < 200 && suspend_begin_irq !== 1'b1; cnt++)
      @(posedge pclk);
    timed_out(cnt, 200);
    chk(32'(cnt >= SC && cnt <= SC + 8), 32'h0000_0001);
    rdchk(`UEBA_OFF_CTRL, 32'h0000_0003);
    rdchk(`UEBA_OFF_IRQ, 32'h0000_0001);
    apb(1'b1, `UEBA_OFF_CTRL, 32'h0000_0000);
    u_host.resume_mark();
    for (cnt = 0; cnt < 20 && suspend_end_irq !== 1'b1; cnt++)
      @(posedge pclk);
    timed_out(cnt, 20);
    frames_on <= 1'b1;
    chk(32'(core_clk_en), 32'h0000_0000);
    rdchk(`UEBA_OFF_IRQ, 32'h0000_0003);
    apb(1'b1, `UEBA_OFF_IRQ, 32'h0000_0003);
    apb(1'b0, `UEBA_OFF_IRQ, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("suspend test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
